// [mrb_regs.svh]
// constants for the manchester data buffer codec
`ifndef MRB_REGS_SVH
`define MRB_REGS_SVH

// ****************************************
// buffer geometry
// ****************************************
`define MRB_BUF_DEPTH      16
`define MRB_PTR_W          4
`define MRB_CNT_W          5
`define MRB_LIM_W          6
`define MRB_TIMER_W        8

// ****************************************
// timing
// ****************************************
`define MRB_CLK_PERIOD_NS  8
`define MRB_TB_PERIOD_NS   1000
`define MRB_TB_CYCLES      ((`MRB_TB_PERIOD_NS + `MRB_CLK_PERIOD_NS - 1) / `MRB_CLK_PERIOD_NS)

// ****************************************
// control field encodings
// ****************************************
`define MRB_OPM_TX         2'h1
`define MRB_OPM_RX         2'h3
`define MRB_THR_4          2'h0
`define MRB_THR_8          2'h1
`define MRB_THR_12         2'h2
`define MRB_THR_EMPTY      2'h3
`define MRB_LVL_4          5'h04
`define MRB_LVL_8          5'h08
`define MRB_LVL_12         5'h0C
`define MRB_LVL_EMPTY      5'h00
`define MRB_LVL_FULL       5'h10

`endif

// [mrb_pkg.sv]
// types shared by the manchester data buffer codec
package mrb_pkg;

   // configuration bits as the host has programmed them
   typedef struct packed {
      logic       op_mode_bit_high;
      logic       op_mode_bit_low;
      logic       irq_threshold_bit_high;
      logic       irq_threshold_bit_low;
      logic       ask_fsk_select;
      logic       limit_scale_bit;
      logic       pattern_mode;
      logic       transparent_mode;
      logic [5:0] lim_min;
      logic [5:0] lim_max;
   } mrb_cfg_t;

   typedef enum logic [2:0] {
      st_idle,
      st_startup,
      st_rx_hunt,
      st_rx_data,
      st_tx_active
   } mrb_state_t;

   typedef enum logic [2:0] {
      ec_short,
      ec_single,
      ec_gap,
      ec_double,
      ec_long
   } mrb_edge_cls_t;

endpackage

// [mrb_edge_timer.sv]
// edge spacing timer and single/double period window classifier
module mrb_edge_timer #(
   parameter int LIM_W = 6,
   parameter int CNT_W = 8
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // timing control
   input  wire logic                  tb_tick,
   input  wire logic                  edge_in,
   input  wire logic                  restart,
   // window limits
   input  wire logic [LIM_W-1:0]      lim_min,
   input  wire logic [LIM_W-1:0]      lim_max,
   // classification
   output mrb_pkg::mrb_edge_cls_t     cls_o,
   output logic                       timeout_o
);

   logic [CNT_W-1:0] edge_spacing_q;
   logic [CNT_W-1:0] sum;
   logic [CNT_W-1:0] diff;
   logic [CNT_W-1:0] lower_double_period_limit;
   logic [CNT_W-1:0] upper_double_period_limit;

   assign sum  = CNT_W'(lim_min) + CNT_W'(lim_max);
   assign diff = CNT_W'(lim_max) - CNT_W'(lim_min);
   // lower double limit
   // halving before the subtraction already gives the rounded-up value
   assign lower_double_period_limit = sum - (diff >> 1);
   assign upper_double_period_limit = sum + CNT_W'((diff + CNT_W'(1)) >> 1);

   // limit timed as value minus one
   assign timeout_o = (edge_spacing_q >= upper_double_period_limit);

   // only single and double windows pass
   always_comb begin
      if (edge_spacing_q < CNT_W'(lim_min)) begin
         cls_o = mrb_pkg::ec_short;
      end else if (edge_spacing_q < CNT_W'(lim_max)) begin
         // single window from the bit-check limits
         cls_o = mrb_pkg::ec_single;
      end else if (edge_spacing_q < lower_double_period_limit) begin
         cls_o = mrb_pkg::ec_gap;
      end else if (edge_spacing_q < upper_double_period_limit) begin
         cls_o = mrb_pkg::ec_double;
      end else begin
         cls_o = mrb_pkg::ec_long;
      end
   end

   // saturates at the timeout so a silent line cannot wrap back into a window
   always_ff @(posedge clk) begin
      if (!rst_n || restart || edge_in) begin
         edge_spacing_q <= '0;
      end else if (tb_tick && !timeout_o) begin
         edge_spacing_q <= edge_spacing_q + CNT_W'(1);
      end
   end

endmodule

// [mrb_codec.sv]
// manchester receive/transmit data buffer controller
//
// Contract
// - upper double limit: sum plus half span
// - start bit opens byte-wise buffer storage
// - seventeenth unread byte overwrites oldest byte
// - rx counter: up per byte, down per read
// - rx interrupt when count rises to threshold
// - bit error: interrupt, back to start-up
// - bit error: bad spacing or centre miss
// - errored byte never enters the buffer
// - control write in rx resets decoder, counter
// - rx bit mapping; pin released or transparent
// - mode bits 01 select transmit
// - pattern mode sends buffer bits as NRZ
// - transmit active only after pll lock
// - loads accepted early; send msb first
// - tx counter; interrupt counting down to threshold
// - control write in tx resets buffer
// - transparent transmit uses the direct pin
// - tx level mapping per coding mode
// - single window uses bit-check limits
// - lower double limit: sum minus half span
// - only single and double spacings valid
// - threshold bits pick 4, 8, 12, empty
`include "mrb_regs.svh"

module mrb_codec #(
   parameter int DEPTH    = `MRB_BUF_DEPTH,
   parameter int TB_CYCLES = `MRB_TB_CYCLES
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // configuration from the serial interface
   input  wire mrb_pkg::mrb_cfg_t  cfg,
   input  wire logic               ctrl_write,
   // host data path
   input  wire logic               host_wr,
   input  wire logic [7:0]         host_wr_data,
   input  wire logic               host_rd,
   output logic [7:0]              host_rd_data,
   output logic [`MRB_CNT_W-1:0]   byte_count,
   output logic                    irq,
   // radio side
   input  wire logic               pll_lock,
   input  wire logic               demod_in,
   output logic                    tx_ask_on,
   output logic                    tx_fsk_high,
   // direct pins
   input  wire logic               serial_in_direct_tx_pin,
   output logic                    serial_out_direct_rx_pin_o,
   output logic                    serial_out_direct_rx_pin_oe_n
);

   // ****************************************
   // declarations
   // ****************************************
   mrb_pkg::mrb_state_t    state_q;
   mrb_pkg::mrb_edge_cls_t cls;
   logic [1:0]             mode;
   logic [2:0]             sync1_q;
   logic [2:0]             sync2_q;
   logic                   lvl_prev_q;
   logic                   lock_s, rx_lvl, tdi_s, rx_edge, tmo;
   logic [$clog2(TB_CYCLES+1)-1:0] tb_cnt_q;
   logic                   tb_tick;
   logic                   rx_on, rx_buf_act, tx_on;
   logic                   half_q, seen_single_q;
   logic [7:0]             rx_shift_q;
   logic [2:0]             rx_bits_q;
   logic                   bit_err, take_bit, start_det, rx_bit_v, rx_wr;
   logic [7:0]             mem_q [DEPTH];
   logic [`MRB_PTR_W-1:0]  wp_q, rp_q;
   logic [`MRB_CNT_W-1:0]  cnt_q, cnt_d, thr_lvl;
   logic                   buf_clr, full, tx_load, push, host_pop, tx_pull, pop, ovf;
   logic                   irq_d;
   logic [7:0]             tx_sh_q;
   logic [2:0]             tx_bits_q;
   logic                   tx_busy_q, tx_phase_q, tx_level;
   logic [6:0]             hp_cnt_q, half_period;
   logic                   hp_end;

   assign mode = {cfg.op_mode_bit_high, cfg.op_mode_bit_low};

   // ****************************************
   // pin synchronisers and time base
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_q    <= 3'h0;
         sync2_q    <= 3'h0;
         lvl_prev_q <= 1'h0;
      end else begin
         sync1_q    <= {pll_lock, serial_in_direct_tx_pin, demod_in};
         sync2_q    <= sync1_q;
         lvl_prev_q <= sync2_q[0];
      end
   end
   assign rx_lvl  = sync2_q[0];
   assign tdi_s   = sync2_q[1];
   assign lock_s  = sync2_q[2];
   assign rx_edge = rx_lvl ^ lvl_prev_q;

   // divider yields one enable per time-base period
   always_ff @(posedge clk) begin
      if (!rst_n || tb_tick) begin
         tb_cnt_q <= '0;
      end else begin
         tb_cnt_q <= tb_cnt_q + 1'b1;
      end
   end
   assign tb_tick = (tb_cnt_q == ($clog2(TB_CYCLES+1))'(TB_CYCLES - 1));

   // ****************************************
   // operating state
   // ****************************************
   assign rx_on      = (state_q == mrb_pkg::st_rx_hunt) || (state_q == mrb_pkg::st_rx_data);
   assign rx_buf_act = rx_on && !cfg.transparent_mode;
   assign tx_on      = (state_q == mrb_pkg::st_tx_active);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= mrb_pkg::st_idle;
      end else begin
         case (state_q)
            mrb_pkg::st_idle: begin
               if (mode == `MRB_OPM_TX || mode == `MRB_OPM_RX) begin
                  state_q <= mrb_pkg::st_startup;
               end
            end
            mrb_pkg::st_startup: begin
               if (mode != `MRB_OPM_TX && mode != `MRB_OPM_RX) begin
                  state_q <= mrb_pkg::st_idle;
               end else if (lock_s) begin
                  state_q <= (mode == `MRB_OPM_TX) ? mrb_pkg::st_tx_active : mrb_pkg::st_rx_hunt;
               end
            end
            mrb_pkg::st_rx_hunt, mrb_pkg::st_rx_data: begin
               if (mode != `MRB_OPM_RX) begin
                  state_q <= mrb_pkg::st_idle;
               end else if (bit_err || ctrl_write) begin
                  state_q <= mrb_pkg::st_startup;
               end else if (start_det) begin
                  state_q <= mrb_pkg::st_rx_data;
               end
            end
            mrb_pkg::st_tx_active: begin
               if (mode != `MRB_OPM_TX) begin
                  state_q <= mrb_pkg::st_idle;
               end
            end
            default: state_q <= mrb_pkg::st_idle;
         endcase
      end
   end

   // ****************************************
   // receive decoder
   // ****************************************
   mrb_edge_timer #(
      .LIM_W (`MRB_LIM_W),
      .CNT_W (`MRB_TIMER_W)
   ) mrb_edge_timer_i (
      .clk       (clk),
      .rst_n     (rst_n),
      .tb_tick   (tb_tick),
      .edge_in   (rx_edge),
      .restart   (!rx_buf_act || ctrl_write),
      .lim_min   (cfg.lim_min),
      .lim_max   (cfg.lim_max),
      .cls_o     (cls),
      .timeout_o (tmo)
   );

   // spacing outside windows, or double from bit boundary
   assign bit_err = (state_q == mrb_pkg::st_rx_data) && !cfg.transparent_mode && !ctrl_write &&
                    (tmo || (rx_edge && (cls == mrb_pkg::ec_short || cls == mrb_pkg::ec_gap ||
                     cls == mrb_pkg::ec_long || (cls == mrb_pkg::ec_double && half_q))));
   assign take_bit  = (state_q == mrb_pkg::st_rx_data) && !cfg.transparent_mode && rx_edge && !bit_err &&
                      !ctrl_write && (cls == mrb_pkg::ec_double || (cls == mrb_pkg::ec_single && half_q));
   // first double after a single-spaced preburst is the start bit
   assign start_det = (state_q == mrb_pkg::st_rx_hunt) && rx_buf_act && rx_edge && !ctrl_write &&
                      (cls == mrb_pkg::ec_double) && seen_single_q;
   assign rx_bit_v  = start_det || take_bit;
   // a byte only completes on a clean bit
   assign rx_wr     = rx_bit_v && (rx_bits_q == 3'h7);

   always_ff @(posedge clk) begin
      if (!rst_n || !rx_buf_act || ctrl_write || bit_err) begin
         half_q        <= 1'h0;
         seen_single_q <= 1'h0;
         rx_shift_q    <= 8'h00;
         rx_bits_q     <= 3'h0;
      end else begin
         if (state_q == mrb_pkg::st_rx_hunt) begin
            seen_single_q <= (rx_edge && cls == mrb_pkg::ec_single) ||
                             (!rx_edge && !tmo && seen_single_q);
         end
         if (rx_edge && cls == mrb_pkg::ec_single && state_q == mrb_pkg::st_rx_data) begin
            half_q <= !half_q;
         end else if (rx_bit_v) begin
            half_q <= 1'h0;
         end
         // level after the centre edge is the bit
         if (rx_bit_v) begin
            rx_shift_q <= {rx_shift_q[6:0], rx_lvl};
            rx_bits_q  <= rx_bits_q + 3'h1;
         end
      end
   end

   // pin released in buffered receive, driven in transparent
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         serial_out_direct_rx_pin_o    <= 1'h0;
         serial_out_direct_rx_pin_oe_n <= 1'h1;
      end else begin
         serial_out_direct_rx_pin_o    <= rx_on && cfg.transparent_mode && rx_lvl;
         serial_out_direct_rx_pin_oe_n <= !(rx_on && cfg.transparent_mode);
      end
   end

   // ****************************************
   // data buffer and byte counter
   // ****************************************
   // control writes clear pointers and count
   assign buf_clr  = ctrl_write || (state_q == mrb_pkg::st_idle);
   assign full     = (cnt_q == `MRB_LVL_FULL);
   // loads in start-up or transmit, none when transparent
   assign tx_load  = host_wr && (mode == `MRB_OPM_TX) && !cfg.transparent_mode && !full &&
                     (state_q == mrb_pkg::st_startup || tx_on);
   assign push     = rx_wr || tx_load;
   assign host_pop = host_rd && (rx_buf_act || state_q == mrb_pkg::st_startup) && (cnt_q != 5'h00);
   assign ovf      = rx_wr && full && !host_pop;
   assign pop      = host_pop || tx_pull || ovf;
   // simultaneous push and pop leave the count alone
   assign cnt_d    = cnt_q + (push ? 5'h01 : 5'h00) - (pop ? 5'h01 : 5'h00);

   always_ff @(posedge clk) begin
      if (!rst_n || buf_clr) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= 5'h00;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= rx_wr ? {rx_shift_q[6:0], rx_lvl} : host_wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         host_rd_data <= 8'h00;
      end else if (host_pop) begin
         host_rd_data <= mem_q[rp_q];
      end
   end
   assign byte_count = cnt_q;

   // ****************************************
   // interrupt events
   // ****************************************
   // threshold select
   always_comb begin
      case ({cfg.irq_threshold_bit_high, cfg.irq_threshold_bit_low})
         `MRB_THR_4:  thr_lvl = `MRB_LVL_4;
         `MRB_THR_8:  thr_lvl = `MRB_LVL_8;
         `MRB_THR_12: thr_lvl = `MRB_LVL_12;
         default:     thr_lvl = `MRB_LVL_EMPTY;
      endcase
   end

   // count crossing in its direction, or receive error
   assign irq_d = (rx_buf_act && rx_wr && !buf_clr && cnt_d > cnt_q && cnt_d == thr_lvl) ||
                  bit_err ||
                  (tx_on && tx_pull && !buf_clr && cnt_d < cnt_q && cnt_d == thr_lvl);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'h0;
      end else begin
         irq <= irq_d;
      end
   end

   // ****************************************
   // transmit serialiser
   // ****************************************
   // half bit in time-base periods, doubled by the scaling bit
   assign half_period = cfg.limit_scale_bit ? {cfg.lim_min, 1'b0} : {1'b0, cfg.lim_min};
   assign hp_end      = tb_tick && ((hp_cnt_q + 7'h01) >= half_period);
   // start as soon as a byte waits
   assign tx_pull     = tx_on && !cfg.transparent_mode && !tx_busy_q && (cnt_q != 5'h00) && !buf_clr;

   always_ff @(posedge clk) begin
      if (!rst_n || !tx_on || cfg.transparent_mode || ctrl_write) begin
         tx_busy_q  <= 1'h0;
         tx_phase_q <= 1'h0;
         tx_bits_q  <= 3'h0;
         hp_cnt_q   <= 7'h00;
         tx_sh_q    <= 8'h00;
      end else if (tx_pull) begin
         tx_busy_q  <= 1'h1;
         tx_sh_q    <= mem_q[rp_q];
         tx_bits_q  <= 3'h0;
         tx_phase_q <= 1'h0;
         hp_cnt_q   <= 7'h00;
      end else if (tx_busy_q && tb_tick) begin
         hp_cnt_q <= hp_end ? 7'h00 : hp_cnt_q + 7'h01;
         if (hp_end) begin
            tx_phase_q <= !tx_phase_q;
            if (tx_phase_q) begin
               tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
               tx_bits_q <= tx_bits_q + 3'h1;
               tx_busy_q <= (tx_bits_q != 3'h7);
            end
         end
      end
   end

   always_comb begin
      if (cfg.transparent_mode) begin
         tx_level = tdi_s;
      end else if (!tx_busy_q) begin
         tx_level = 1'b0;
      end else if (cfg.pattern_mode) begin
         tx_level = tx_sh_q[7];
      end else begin
         tx_level = tx_phase_q ? tx_sh_q[7] : !tx_sh_q[7];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_ask_on   <= 1'h0;
         tx_fsk_high <= 1'h0;
      end else begin
         tx_ask_on   <= tx_on && cfg.ask_fsk_select && tx_level;
         tx_fsk_high <= tx_on && !cfg.ask_fsk_select && tx_level;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   count_bound_a: assert property (cnt_q <= `MRB_LVL_FULL)
      else $error("byte count above buffer depth");
   ovf_hold_a: assert property (ovf && !buf_clr |=> cnt_q == `MRB_LVL_FULL && rp_q == $past(rp_q) + 1'b1)
      else $error("overflow did not overwrite oldest byte");
   rx_count_a: assert property (rx_wr && !full && !host_pop && !buf_clr |=> cnt_q == $past(cnt_q) + 5'h01)
      else $error("received byte not counted");
   rx_irq_a: assert property (rx_wr && !buf_clr && !host_pop && cnt_q == thr_lvl - 5'h01 && thr_lvl != 5'h00
                              |=> irq)
      else $error("rx threshold interrupt missing");
   err_restart_a: assert property (bit_err |=> state_q == mrb_pkg::st_startup && irq)
      else $error("bit error did not restart with interrupt");
   err_discard_a: assert property (bit_err |-> !push ##1 cnt_q == $past(cnt_q) - ($past(host_pop) ? 5'h01 : 5'h00))
      else $error("errored byte reached the buffer");
   ctrl_clear_a: assert property (ctrl_write |=> cnt_q == 5'h00 && wp_q == rp_q)
      else $error("control write did not clear buffer");
   rx_pin_a: assert property (rx_buf_act |=> serial_out_direct_rx_pin_oe_n)
      else $error("rx pin driven in buffered receive");
   tx_enter_a: assert property (state_q == mrb_pkg::st_idle && mode == `MRB_OPM_TX
                                |=> state_q == mrb_pkg::st_startup)
      else $error("transmit selection ignored");
   lock_gate_a: assert property (state_q == mrb_pkg::st_startup && !lock_s |=> !tx_on)
      else $error("transmit active before lock");
   msb_first_a: assert property (tx_pull |=> tx_sh_q == $past(mem_q[rp_q]) && tx_bits_q == 3'h0)
      else $error("serialiser not loaded msb first");
   tx_irq_a: assert property (tx_pull && !push && cnt_q == thr_lvl + 5'h01 |=> irq)
      else $error("tx threshold interrupt missing");
   pattern_a: assert property (tx_on && tx_busy_q && cfg.pattern_mode && !cfg.transparent_mode
                               |-> tx_level == tx_sh_q[7])
      else $error("pattern level differs from buffer bit");
   transp_tx_a: assert property (tx_on && cfg.transparent_mode && !cfg.ask_fsk_select
                                 |=> tx_fsk_high == $past(tdi_s))
      else $error("transparent transmit not following pin");

   start_seen_c: cover property (start_det ##[1:1000] rx_wr);
   overflow_c:   cover property (ovf);
   tx_byte_c:    cover property (tx_pull ##[1:1000] !tx_busy_q);

endmodule

// [mrb_remote_tx.sv]
// remote manchester transmitter that drives the demodulator line
module mrb_remote_tx #(
   parameter int HALF = 60
) (
   // clock and line
   input  wire logic clk,
   output logic      demod_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial demod_in = 1'h0;
   // steady line level, for transparent receive
   task automatic hold(input logic v);
      demod_in <= v;
   endtask
   // ****************************************
   // frame sender
   // ****************************************
   // zero preburst, so the first data bit must be 1
   task automatic send(input int nbits, input logic [255:0] d);
      logic b;
      for (int i = -4; i < nbits; i++) begin
         b = (i < 0) ? 1'h0 : d[255-i];
         demod_in <= !b;
         repeat (HALF) @(posedge clk);
         demod_in <= b;
         repeat (HALF) @(posedge clk);
      end
   endtask
endmodule

// [mrb_codec_tb.sv]
// self-checking bench for the manchester data buffer codec
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR %0t got %0h expected %0h", $time, (a), (e)); end end
module mrb_codec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk = 1'h0;
   logic              rst_n, ctrl_write, host_wr, host_rd, pll_lock, tx_pin, demod;
   mrb_pkg::mrb_cfg_t cfg;
   logic [7:0]        wdata, rdata;
   logic [4:0]        count;
   logic              irq, ask, fsk, pin_o, pin_oe_n;
   logic [255:0]      d;
   int                fail_count, tests_run, irqs, cyc;
   mrb_codec #(.TB_CYCLES(4)) mrb_codec_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .ctrl_write(ctrl_write),
      .host_wr(host_wr), .host_wr_data(wdata), .host_rd(host_rd), .host_rd_data(rdata), .byte_count(count),
      .irq(irq), .pll_lock(pll_lock), .demod_in(demod), .tx_ask_on(ask), .tx_fsk_high(fsk),
      .serial_in_direct_tx_pin(tx_pin), .serial_out_direct_rx_pin_o(pin_o),
      .serial_out_direct_rx_pin_oe_n(pin_oe_n));
   mrb_remote_tx #(.HALF(60)) mrb_remote_tx_i (.clk(clk), .demod_in(demod));
   always #4 clk = ~clk;
   // ****************************************
   // helpers
   // ****************************************
   // run is about 26k cycles, so 60k means a hang
   always @(posedge clk) begin
      cyc++;
      irqs += irq;
      if (cyc == 60000) begin
         $display("ERROR %0t run timed out", $time);
         fail_count++;
         results();
      end
   end
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      tick();
      s = 1'h0;
      tick();
   endtask
   task automatic mode(logic [1:0] m, logic t, logic p, logic a, logic [1:0] thr);
      // rate and modulation set before mode bits
      // limits not sensitivity-tuned, no bit-check here
      cfg = '{1'h0, 1'h0, thr[1], thr[0], a, 1'h0, p, t, 6'h0A, 6'h14};
      tick(2);
      {cfg.op_mode_bit_high, cfg.op_mode_bit_low} = m;
      tick(8);
      irqs = 0;
   endtask
   task automatic rd_chk(logic [7:0] e);
      host_rd = 1'h1;
      tick();
      host_rd = 1'h0;
      `CHK(rdata, e)
      tick();
   endtask
   task automatic wr(logic [7:0] v);
      wdata = v;
      pulse(host_wr);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_rx_thr();
      pll_lock = 1'h1;
      mode(2'h3, 1'h0, 1'h0, 1'h0, 2'h0);
      mrb_remote_tx_i.send(32, {32'hA53C96F0, 224'h0});
      tick(400);
      `CHK(irqs, 2)
      `CHK(count, 5'h04)
      rd_chk(8'hA5);
      rd_chk(8'h3C);
      rd_chk(8'h96);
      rd_chk(8'hF0);
      `CHK(count, 5'h00)
      `CHK(pin_oe_n, 1'h1)
      $display("rx threshold done");
   endtask
   task automatic t_rx_err();
      mode(2'h3, 1'h0, 1'h0, 1'h0, 2'h3);
      mrb_remote_tx_i.send(12, {16'hC3F0, 240'h0});
      tick(400);
      `CHK(count, 5'h01)
      `CHK(irqs, 1)
      pulse(ctrl_write);
      `CHK(count, 5'h00)
      $display("rx error done");
   endtask
   task automatic t_rx_ovf();
      mode(2'h3, 1'h0, 1'h0, 1'h0, 2'h2);
      for (int k = 0; k < 17; k++)
         d[255-8*k -: 8] = 8'h80 | 8'(k);
      mrb_remote_tx_i.send(136, d);
      tick(400);
      `CHK(count, 5'h10)
      rd_chk(8'h81);
      `CHK(irqs, 2)
      $display("rx overflow done");
   endtask
   task automatic t_rx_transp();
      mode(2'h3, 1'h1, 1'h0, 1'h0, 2'h0);
      mrb_remote_tx_i.hold(1'h1);
      tick(8);
      `CHK({pin_oe_n, pin_o}, 2'h1)
      mrb_remote_tx_i.hold(1'h0);
      tick(8);
      `CHK({pin_oe_n, pin_o}, 2'h0)
      $display("rx transparent done");
   endtask
   task automatic t_tx(logic p, logic a, logic [7:0] v);
      logic b;
      pll_lock = 1'h0;
      mode(2'h1, 1'h0, p, a, 2'h3);
      wr(8'h11);
      wr(8'h22);
      wr(8'h33);
      `CHK(count, 5'h03)
      `CHK(ask | fsk, 1'h0)
      pulse(ctrl_write);
      `CHK(count, 5'h00)
      // one byte only, so no pacing gap arises
      wr(v);
      pll_lock = 1'h1;
      for (int n = 0; n < 200 && (a ? ask : fsk) !== 1'h1; n++)
         tick();
      tick(20);
      for (int h = p ? 0 : 1; h < 16; h++) begin
         b = v[7-h/2];
         `CHK(a ? ask : fsk, p ? b : (h[0] ? b : !b))
         tick(40);
      end
      `CHK(irqs, 1)
      $display("tx done");
   endtask
   task automatic t_transp();
      mode(2'h1, 1'h1, 1'h0, 1'h0, 2'h0);
      tx_pin = 1'h1;
      tick(8);
      `CHK(fsk, 1'h1)
      wr(8'h5A);
      tx_pin = 1'h0;
      tick(8);
      `CHK(fsk, 1'h0)
      `CHK(count, 5'h00)
      $display("tx transparent done");
   endtask
   initial begin
      {rst_n, ctrl_write, host_wr, host_rd, pll_lock, tx_pin} = 6'h0;
      {wdata, d, cfg} = '0;
      tick(4);
      rst_n = 1'h1;
      tick();
      `CHK({count, irq, pin_oe_n, ask, fsk}, 9'h004)
      t_rx_thr();
      t_rx_err();
      t_rx_ovf();
      t_rx_transp();
      t_tx(1'h0, 1'h0, 8'hA5);
      t_tx(1'h1, 1'h1, 8'h96);
      t_transp();
      results();
   end
endmodule
